// ---- tdm_switch_host_port_tb.sv ----
`timescale 1ns/1ns
module tdm_switch_host_port_tb;
	logic clk, reset, req, req_write, ready, done, style_ds;
	logic [13:0] req_addr;
	logic [15:0] req_wdata, rdata;
	int err_count, tests_run, seed;
	logic [15:0] mem [int];
	tsp_bus_if bus();
	tsp_device i_tsp_device (.clk(clk), .reset(reset), .bus(bus), .style_ds(style_ds));
	// short reset wait keeps the run brief
	tsp_host #(.WAIT_CYC(10)) i_tsp_host (.clk(clk), .reset(reset), .bus(bus),
		.req(req), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.ready(ready), .done(done), .rdata(rdata));
	tsp_assertions i_tsp_assertions (.clk(clk), .reset(reset), .select_n(bus.select_n),
		.strobe_or_read_strobe(bus.strobe_or_read_strobe),
		.rw_or_write_strobe(bus.rw_or_write_strobe), .data_host_oe_n(bus.data_host_oe_n),
		.data_dev_oe_n(bus.data_dev_oe_n), .ack_oe_n(bus.ack_oe_n),
		.transfer_ack_ready(bus.transfer_ack_ready), .bus_style_strap(bus.bus_style_strap));
	// ****
	// tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d);
		logic [15:0] e;
		int n;
		e = w ? d : mem[a];
		n = 0;
		while (ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, ready}, 16'h0001);
		req = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge clk);
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			// the wire must carry the word while the ack is out
			if (bus.select_n === 1'b0 && bus.transfer_ack_ready !== bus.bus_style_strap)
				chk(bus.host_data_lines, e);
			@(negedge clk);
			n++;
		end
		chk({15'h0000, done}, 16'h0001);
		if (!w)
			chk(rdata, e);
		if (w)
			mem[a] = d;
	endtask
	task automatic run_style(input logic s);
		logic [13:0] a [6];
		int i;
		mem.delete();
		bus.bus_style_strap = s;
		reset = 1'b1;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		chk({15'h0000, ready}, 16'h0000);
		a[0] = 14'h0000;
		a[1] = 14'h3fff;
		for (i = 2; i < 6; i++)
			a[i] = 14'($random(seed));
		for (i = 0; i < 6; i++)
			access(1'b1, a[i], 16'($random(seed)));
		for (i = 5; i >= 0; i--)
			access(1'b0, a[i], 16'h0000);
		access(1'b1, a[1], 16'hffff);
		access(1'b0, a[1], 16'h0000);
		chk({15'h0000, style_ds}, {15'h0000, s});
		$display("test style %0d done", s);
	endtask
	task automatic close_out;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ****
	// run
	// ****
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		seed = 2;
		reset = 1'b1;
		req = 1'b0;
		req_write = 1'b0;
		req_addr = 14'h0000;
		req_wdata = 16'h0000;
		bus.bus_style_strap = 1'b1;
		@(negedge clk);
		run_style(1'b1);
		run_style(1'b0);
		close_out();
	end
	initial begin
		#20000;
		err_count++;
		close_out();
	end
endmodule

// ---- tsp_assertions.sv ----
`timescale 1ns/1ns
// ****
// port checks
// ****
module tsp_assertions (
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic select_n, // select
	input wire logic strobe_or_read_strobe, // strobe
	input wire logic rw_or_write_strobe, // rw
	input wire logic data_host_oe_n, // host drive
	input wire logic data_dev_oe_n, // dev drive
	input wire logic ack_oe_n, // ack drive
	input wire logic transfer_ack_ready, // ack wire
	input wire logic bus_style_strap // style
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic ack_on;
	// released ack sits at the strap level, so any other level means signalling
	assign ack_on = transfer_ack_ready != bus_style_strap;
	a_idle_quiet: assert property (select_n [*6] |-> data_dev_oe_n && ack_oe_n)
		else $error("device active while deselected");
	a_data_release: assert property ($rose(select_n) |-> ##[1:5] data_dev_oe_n)
		else $error("data not released");
	a_ack_release: assert property ($rose(select_n) |-> ##[1:5] (ack_oe_n && !ack_on))
		else $error("ack not released");
	a_read_drive: assert property ($fell(data_dev_oe_n) |-> !select_n &&
		(bus_style_strap ? rw_or_write_strobe : !strobe_or_read_strobe))
		else $error("data driven outside read");
	a_no_clash: assert property (!data_dev_oe_n |-> data_host_oe_n)
		else $error("both ends drive data");
	a_ds_ack: assert property (bus_style_strap && $rose(ack_on) |->
		!select_n && !strobe_or_read_strobe)
		else $error("ack without strobe");
	a_ss_ready: assert property (!bus_style_strap && $rose(ack_on) |-> !select_n &&
		!(strobe_or_read_strobe && rw_or_write_strobe) && $past(!ack_oe_n))
		else $error("ready rise wrong");
	a_ack_bound: assert property ($fell(select_n) |-> ##[2:12] ack_on)
		else $error("no ack in time");
	a_rw_hold: assert property (bus_style_strap && !select_n && $past(!select_n) |->
		$stable(rw_or_write_strobe))
		else $error("rw moved in access");
endmodule

// ---- tsp_bus_if.sv ----
`timescale 1ns/1ns
interface tsp_bus_if;
	logic [13:0] host_address_lines;
	logic [15:0] data_from_host;
	logic data_host_oe_n;
	logic [15:0] data_from_dev;
	logic data_dev_oe_n;
	logic select_n;
	logic strobe_or_read_strobe;
	logic rw_or_write_strobe;
	logic ack_out;
	logic ack_oe_n;
	logic bus_style_strap;
	logic [15:0] host_data_lines;
	logic transfer_ack_ready;
	// wire resolution; the pull sets the released acknowledge level per style
	// undriven data lines show the inverse of the last read word, so a late sample shows up
	assign host_data_lines = !data_dev_oe_n ? data_from_dev :
		(!data_host_oe_n ? data_from_host : ~data_from_dev);
	assign transfer_ack_ready = !ack_oe_n ? ack_out : bus_style_strap;
	modport dev (
		input host_address_lines, data_from_host, data_host_oe_n, select_n,
		input strobe_or_read_strobe, rw_or_write_strobe, bus_style_strap,
		input host_data_lines,
		output data_from_dev, data_dev_oe_n, ack_out, ack_oe_n
	);
	modport host (
		output host_address_lines, data_from_host, data_host_oe_n, select_n,
		output strobe_or_read_strobe, rw_or_write_strobe,
		input bus_style_strap, host_data_lines, transfer_ack_ready,
		input data_from_dev, data_dev_oe_n
	);
endinterface

// ---- tsp_device.sv ----
`timescale 1ns/1ns
module tsp_device #(
	parameter int DEPTH = tsp_pkg::MEM_DEPTH
) (
	input wire logic clk, // system clock
	input wire logic reset, // async active-high reset
	tsp_bus_if.dev bus, // host port pins
	output logic style_ds // latched bus style, 1 = data-strobe
);
	// ************************************************
	// parameter checks
	// ************************************************
	// the address pins reach no more than 2**ADDR_W words
	if (DEPTH < 1 || DEPTH > (1 << tsp_pkg::ADDR_W)) begin
		$error("tsp_device: DEPTH out of range");
	end
	// the answer wait is counted in a two-bit counter
	if (tsp_pkg::ACK_DELAY_CYC < 1 || tsp_pkg::ACK_DELAY_CYC > 3) begin
		$error("tsp_device: ACK_DELAY_CYC out of range");
	end
	// the word store and the data pins are one fixed word wide
	if (tsp_pkg::DATA_W != 16) begin
		$error("tsp_device: DATA_W must be 16");
	end

	// ************************************************
	// pin synchronisers (two flops, nothing reads stage one)
	// ************************************************
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1 <= 4'hf;
			sync2 <= 4'hf;
		end else begin
			sync1 <= {bus.bus_style_strap, bus.select_n, bus.strobe_or_read_strobe,
				bus.rw_or_write_strobe};
			sync2 <= sync1;
		end
	end
	wire strap_s = sync2[3];
	wire sel_n_s = sync2[2];
	wire strobe_or_read_strobe_s = sync2[1];
	wire rw_wr_s = sync2[0];

	// ************************************************
	// bus style strap
	// ************************************************
	// the strap is taken once, when the synchroniser has filled with the pin level;
	// before that its flops still hold their reset value
	logic strap_taken;
	logic [1:0] strap_age;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_age <= 2'h0;
		end else if (strap_age != 2'h2) begin
			strap_age <= strap_age + 2'h1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_taken <= 1'b0;
			style_ds <= 1'b1;
		end else if (!strap_taken && strap_age == 2'h2) begin
			strap_taken <= 1'b1;
			style_ds <= strap_s; // [RULE13]
		end
	end

	// ************************************************
	// access decode
	// ************************************************
	logic req_rd;
	logic req_wr;
	always_comb begin
		req_rd = 1'b0;
		req_wr = 1'b0;
		if (strap_taken && !sel_n_s) begin // [RULE2]
			if (style_ds) begin
				req_rd = !strobe_or_read_strobe_s && rw_wr_s; // [RULE5]
				req_wr = !strobe_or_read_strobe_s && !rw_wr_s; // [RULE5]
			end else begin
				req_rd = !strobe_or_read_strobe_s; // [RULE7]
				req_wr = !rw_wr_s; // [RULE6]
			end
		end
	end

	// ************************************************
	// access sequencing
	// ************************************************
	// one access at a time; a new one waits until select has been seen high
	typedef enum logic [1:0] {tsp_idle, tsp_busy, tsp_done} tsp_state_e;
	tsp_state_e state;
	logic [1:0] wait_cnt;
	logic is_read;
	logic [15:0] mem [DEPTH];
	logic [15:0] rd_data;
	logic [13:0] addr;
	assign addr = bus.host_address_lines; // [RULE12]

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= tsp_idle;
		end else begin
			case (state)
				tsp_idle: begin
					if (req_rd || req_wr)
						state <= tsp_busy;
				end
				tsp_busy: begin
					if (wait_cnt <= 2'h1)
						state <= tsp_done;
				end
				tsp_done: begin
					// hold the answer until the host lets go of select
					if (sel_n_s)
						state <= tsp_idle; // [RULE11]
				end
				default: begin
					state <= tsp_idle;
				end
			endcase
		end
	end

	// fixed wait between taking an access and answering it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_cnt <= 2'h0;
		end else if (state == tsp_idle) begin
			wait_cnt <= 2'(tsp_pkg::ACK_DELAY_CYC);
		end else if (state == tsp_busy && wait_cnt > 2'h1) begin
			wait_cnt <= wait_cnt - 2'h1;
		end
	end

	// direction of the access in progress, taken with the access
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			is_read <= 1'b0;
		end else if (state == tsp_idle && (req_rd || req_wr)) begin
			is_read <= req_rd;
		end
	end

	// ************************************************
	// word store
	// ************************************************
	// address and data pins have been steady for two cycles when the access is taken,
	// so they are read here without synchronisers
	always_ff @(posedge clk) begin
		if (state == tsp_idle && req_wr && 32'(addr) < DEPTH)
			mem[addr] <= bus.host_data_lines; // [RULE1]
	end

	// locations beyond the store read as zero
	always_ff @(posedge clk) begin
		if (state == tsp_idle && req_rd)
			rd_data <= (32'(addr) < DEPTH) ? mem[addr] : 16'h0000;
	end

	// ************************************************
	// pin drivers
	// ************************************************
	// the data word follows the read buffer; only the enable decides if it reaches the pins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus.data_from_dev <= 16'h0000;
		end else begin
			bus.data_from_dev <= rd_data;
		end
	end

	// data lines are driven only inside a read that the host still selects
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus.data_dev_oe_n <= 1'b1;
		end else begin
			bus.data_dev_oe_n <= !(state != tsp_idle && is_read && !sel_n_s); // [RULE3]
		end
	end

	// the ack pin is released except while answering; in separate-strobe style it is
	// driven low during the wait so that the host sees ready rise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus.ack_oe_n <= 1'b1;
		end else if (state == tsp_done && !sel_n_s) begin
			bus.ack_oe_n <= 1'b0; // [RULE8] [RULE9]
		end else if (state == tsp_busy) begin
			bus.ack_oe_n <= style_ds;
		end else begin
			bus.ack_oe_n <= 1'b1; // [RULE10]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bus.ack_out <= 1'b1;
		end else if (state == tsp_done) begin
			bus.ack_out <= !style_ds; // [RULE8] [RULE9]
		end else begin
			bus.ack_out <= 1'b0;
		end
	end
endmodule

// ---- tsp_host.sv ----
`timescale 1ns/1ns
module tsp_host #(
	parameter int WAIT_CYC = tsp_pkg::RESET_WAIT_CYC
) (
	input wire logic clk, // system clock
	input wire logic reset, // async active-high reset
	tsp_bus_if.host bus, // port pins
	input wire logic req, // start access, level until ready
	input wire logic req_write, // 1 = write
	input wire logic [13:0] req_addr, // access address
	input wire logic [15:0] req_wdata, // write data
	output logic ready, // may take req
	output logic done, // one-cycle pulse at end
	output logic [15:0] rdata // read data
);
	if (WAIT_CYC < 1) begin
		$error("tsp_host: WAIT_CYC must be positive");
	end

	logic [1:0] s1;
	logic [1:0] s2;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1 <= 2'h0;
			s2 <= 2'h0;
		end else begin
			s1 <= {bus.bus_style_strap, bus.transfer_ack_ready};
			s2 <= s1;
		end
	end
	wire style_ds = s2[1];
	wire ack_s = s2[0];
	logic ack_prev;

	typedef enum logic [1:0] {th_boot, th_idle, th_wait, th_end} tsp_hstate_e;
	tsp_hstate_e state;
	logic [31:0] cnt;
	logic wr;
	wire complete = style_ds ? !ack_s : (ack_s && !ack_prev); // [RULE8] [RULE9]
	assign ready = (state == th_idle);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= th_boot;
			cnt <= 32'h0;
			wr <= 1'b0;
			ack_prev <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			bus.host_address_lines <= 14'h0000;
			bus.data_from_host <= 16'h0000;
			bus.data_host_oe_n <= 1'b1;
			bus.select_n <= 1'b1;
			bus.strobe_or_read_strobe <= 1'b1;
			bus.rw_or_write_strobe <= 1'b1;
		end else begin
			ack_prev <= ack_s;
			done <= 1'b0;
			case (state)
				th_boot: begin
					cnt <= cnt + 32'h1;
					if (cnt >= 32'(WAIT_CYC))
						state <= th_idle; // [RULE14]
				end
				th_idle: begin
					if (req) begin
						wr <= req_write;
						bus.host_address_lines <= req_addr; // [RULE12]
						bus.data_from_host <= req_wdata; // [RULE1]
						bus.data_host_oe_n <= !req_write;
						bus.select_n <= 1'b0; // [RULE2]
						if (style_ds) begin
							bus.rw_or_write_strobe <= !req_write; // [RULE4]
							bus.strobe_or_read_strobe <= 1'b0; // [RULE5]
						end else begin
							bus.rw_or_write_strobe <= !req_write; // [RULE6]
							bus.strobe_or_read_strobe <= req_write; // [RULE7]
						end
						state <= th_wait;
					end
				end
				th_wait: begin
					if (complete) begin
						rdata <= bus.host_data_lines;
						bus.select_n <= 1'b1; // [RULE11]
						bus.strobe_or_read_strobe <= 1'b1;
						bus.rw_or_write_strobe <= 1'b1;
						bus.data_host_oe_n <= 1'b1;
						done <= 1'b1;
						state <= th_end;
					end
				end
				th_end: begin
					// wait for the released acknowledge to settle back
					if (style_ds ? ack_s : !ack_s)
						state <= th_idle;
				end
				default: state <= th_boot;
			endcase
		end
	end
endmodule

// ---- tsp_pkg.sv ----
// Behaviour
// RULE1: host data path is sixteen bits wide
// RULE2: select low opens access; high ignored
// RULE3: device drives data on read, else released
// RULE4: data-strobe style: rw high read, low write
// RULE5: data-strobe access needs strobe and select low
// RULE6: separate-strobe style: write strobe low writes
// RULE7: separate-strobe style: read strobe low reads
// RULE8: data-strobe style: acknowledge low marks completion
// RULE9: separate-strobe style: ready rising marks completion
// RULE10: acknowledge/ready released when not signalling; in separate-strobe style the device here drives ready low during the wait
// RULE11: acknowledge/ready released after select deasserts
// RULE12: fourteen-bit address selects registers and memory; the device here decodes it only into the word store
// RULE13: strap high selects data-strobe, low separate-strobe
// RULE14: host waits 500 us after reset release
package tsp_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 14;
	localparam int CLK_MHZ = 100;
	localparam int RESET_WAIT_US = 500;
	localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
	localparam int ACK_DELAY_CYC = 2;
	localparam int MEM_DEPTH = 16384;
endpackage
